// ### hdl/gxp_pkg.sv
// Shared constants, register indices and state encodings for the GPIO expander core
package gxp_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int GXP_PORT_W = 8; // One port byte
  localparam int GXP_IO_W = 16; // Two ports of pins
  localparam int GXP_STRAP_W = 3; // Address strap pins

  // ****************************************
  // Register indices (command byte values)
  // ****************************************
  localparam logic [7:0] GXP_REG_IN0 = 8'h00; // Input port 0
  localparam logic [7:0] GXP_REG_IN1 = 8'h01; // Input port 1
  localparam logic [7:0] GXP_REG_OUT0 = 8'h02; // Output port 0
  localparam logic [7:0] GXP_REG_OUT1 = 8'h03; // Output port 1
  localparam logic [7:0] GXP_REG_POL0 = 8'h04; // Polarity inversion 0
  localparam logic [7:0] GXP_REG_POL1 = 8'h05; // Polarity inversion 1
  localparam logic [7:0] GXP_REG_CFG0 = 8'h06; // Direction 0
  localparam logic [7:0] GXP_REG_CFG1 = 8'h07; // Direction 1
  localparam logic [7:0] GXP_REG_PU0 = 8'h08; // Pull-up enable 0
  localparam logic [7:0] GXP_REG_PU1 = 8'h09; // Pull-up enable 1
  localparam logic [7:0] GXP_PAIR_FLIP = 8'h01; // Toggles within a pair

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [15:0] GXP_OUT_RST = 16'hFFFF; // Outputs high
  localparam logic [15:0] GXP_POL_RST = 16'h0000; // No inversion
  localparam logic [15:0] GXP_CFG_RST = 16'hFFFF; // All inputs
  localparam logic [15:0] GXP_PU_RST = 16'hFFFF; // Pull-ups on
  localparam logic [7:0] GXP_VOID_BYTE = 8'h00; // Unmapped read value

  // ****************************************
  // Bus engine
  // ****************************************
  localparam logic [3:0] GXP_BYTE_BITS = 4'h8; // Bits per byte
  localparam logic [3:0] GXP_CNT_CLR = 4'h0; // Bit counter start
  localparam logic [3:0] GXP_CNT_ONE = 4'h1; // Bit counter step

  // Bus engine states
  typedef enum logic [3:0] {
    GXP_ST_IDLE,
    GXP_ST_ADDR,
    GXP_ST_ADDR_ACK,
    GXP_ST_CMD,
    GXP_ST_CMD_ACK,
    GXP_ST_WDATA,
    GXP_ST_WACK,
    GXP_ST_RDATA,
    GXP_ST_RACK,
    GXP_ST_IGNORE
  } gxp_state_type;

endpackage

// ### hdl/gxp_sync.sv
// Two-flop level synchroniser, vector wide
`timescale 1ns/1ps
`default_nettype none
module gxp_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  // Both stages, first read only by second
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stab;
  } gxp_sync_state_type;

  gxp_sync_state_type st_ff; // Registered stages
  gxp_sync_state_type nxt_st; // Next stages

  // Shift one stage per edge
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.meta = d;
    nxt_st.stab = st_ff.meta;
  end

  // Stage registers
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign q = st_ff.stab;

endmodule
`default_nettype wire

// ### hdl/gxp_scl_sampler.sv
// SDA sampler on the bus clock, posts each bit with a toggle
`timescale 1ns/1ps
`default_nettype none
module gxp_scl_sampler (
  input wire logic scl_clk,
  input wire logic rst_b,
  input wire logic sda_in,
  output logic bit_out,
  output logic tog_out
);

  // Sampled bit and event toggle
  typedef struct packed {
    logic bit_v;
    logic tog;
  } gxp_smp_state_type;

  gxp_smp_state_type st_ff; // Registered state
  gxp_smp_state_type nxt_st; // Next state

  // Bit held stable until the next rising edge
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.bit_v = sda_in;
    nxt_st.tog = ~st_ff.tog;
  end

  // Runs only while the master clocks
  always_ff @(posedge scl_clk or negedge rst_b)
  begin
    if (!rst_b)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign bit_out = st_ff.bit_v;
  assign tog_out = st_ff.tog;

endmodule
`default_nettype wire

// ### hdl/gxp_core.sv
// Two-wire slave with 16-bit GPIO ports, pull-ups and change interrupt
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Input pin: both drivers off
// - Output pin driven from output register
// - Pull-ups on at reset, off on 0
// - Reset loads registers and bus engine
// - Any input edge raises interrupt
// - Clear on return or port read
// - Read clears at acknowledge rising edge
// - Later changes raise interrupt again
// - Output pins never interrupt
// - Output-to-input switch may interrupt
// - Address write then command selects register
// - Write alternates to pair partner
// - Unlimited write bytes per transfer
// - Read after repeated start returns selected
// - Read alternates within pair
// - Pointer stays at partner of last read
// - Read data captured at acknowledge rise
// - Direction bit 1 input, 0 output
// - Input ports show live pins, read-only
// - Polarity bit inverts input view
// - Output reads return written value
module gxp_core
  import gxp_pkg::*;
#(
  parameter logic [3:0] ADDR_BASE = 4'hA // Arbitrary upper address bits
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic scl_clk,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [gxp_pkg::GXP_STRAP_W-1:0] addr_pin,
  input wire logic [gxp_pkg::GXP_IO_W-1:0] gpio_in,
  output logic [gxp_pkg::GXP_IO_W-1:0] gpio_out,
  output logic [gxp_pkg::GXP_IO_W-1:0] gpio_oe,
  output logic [gxp_pkg::GXP_IO_W-1:0] gpio_pu_en,
  output logic int_out,
  output logic int_oe
);
  import gxp_pkg::*;

  // ****************************************
  // State
  // ****************************************

  // Synchronised vector: pins, straps, clock, data, toggle
  localparam int SYNC_W = GXP_IO_W + GXP_STRAP_W + 3;

  // Whole core state
  typedef struct packed {
    gxp_state_type st; // Bus engine state
    logic [3:0] bcnt; // Bits seen in byte
    logic [7:0] rx; // Receive shifter
    logic [7:0] tx; // Transmit shifter
    logic rw; // Direction bit of address
    logic acked; // Master acked last read byte
    logic [7:0] ptr; // Register pointer
    logic sda_oe; // Pull SDA low
    logic [15:0] outp; // Output port registers
    logic [15:0] pol; // Polarity inversion
    logic [15:0] cfg; // Direction
    logic [15:0] pu; // Pull-up enables
    logic [15:0] snap; // Raw levels last captured
    logic init_done; // Snapshot taken after reset
    logic int_oe; // Interrupt pending
    logic scl_d; // Previous synced SCL
    logic sda_d; // Previous synced SDA
    logic tog_d; // Previous synced toggle
  } gxp_core_state_type;

  gxp_core_state_type q_ff; // Registered state
  gxp_core_state_type nxt_q; // Next state

  logic smp_bit; // Bit sampled on SCL rise
  logic smp_tog; // Event toggle from SCL domain
  logic [SYNC_W-1:0] sync_d; // Raw asynchronous inputs
  logic [SYNC_W-1:0] sync_q; // Synchronised inputs
  logic [15:0] pin_s; // Synced pin levels
  logic [2:0] strap_s; // Synced address straps
  logic scl_s; // Synced SCL level
  logic sda_s; // Synced SDA level
  logic tog_s; // Synced toggle
  logic [15:0] in_val; // Input port view
  logic rise_ev; // SCL rose, bit valid
  logic fall_ev; // SCL fell
  logic start_ev; // Start or repeated start
  logic stop_ev; // Stop condition

  // ****************************************
  // Crossings
  // ****************************************

  // Bit sampler on the bus clock
  gxp_scl_sampler u_smp (
    .scl_clk(scl_clk),
    .rst_b(rst_b),
    .sda_in(sda_in),
    .bit_out(smp_bit),
    .tog_out(smp_tog)
  );

  assign sync_d = {gpio_in, addr_pin, scl_clk, sda_in, smp_tog};

  // All asynchronous levels except the sampled bit through two flops
  gxp_sync #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .clk(ref_clk),
    .rst_b(rst_b),
    .d(sync_d),
    .q(sync_q)
  );

  assign {pin_s, strap_s, scl_s, sda_s, tog_s} = sync_q;

  // ****************************************
  // Bus events
  // ****************************************

  // Toggle change marks a rising SCL edge
  assign rise_ev = tog_s ^ q_ff.tog_d;
  assign fall_ev = q_ff.scl_d & ~scl_s;
  // SDA edges while SCL stays high
  assign start_ev = scl_s & q_ff.scl_d & q_ff.sda_d & ~sda_s;
  assign stop_ev = scl_s & q_ff.scl_d & ~q_ff.sda_d & sda_s;

  // Live pins through polarity inversion
  assign in_val = pin_s ^ q_ff.pol;

  // ****************************************
  // Register read decode
  // ****************************************

  // Byte returned for a register index
  function automatic logic [7:0] reg_read(
    input logic [7:0] idx,
    input logic [15:0] inv,
    input gxp_core_state_type s
  );
    logic [7:0] r;
    case (idx)
      GXP_REG_IN0: r = inv[7:0];
      GXP_REG_IN1: r = inv[15:8];
      GXP_REG_OUT0: r = s.outp[7:0];
      GXP_REG_OUT1: r = s.outp[15:8];
      GXP_REG_POL0: r = s.pol[7:0];
      GXP_REG_POL1: r = s.pol[15:8];
      GXP_REG_CFG0: r = s.cfg[7:0];
      GXP_REG_CFG1: r = s.cfg[15:8];
      GXP_REG_PU0: r = s.pu[7:0];
      GXP_REG_PU1: r = s.pu[15:8];
      default: r = GXP_VOID_BYTE;
    endcase
    return r;
  endfunction

  // ****************************************
  // Next state
  // ****************************************

  // Bus engine, registers and interrupt
  always_comb
  begin
    nxt_q = q_ff;
    nxt_q.scl_d = scl_s;
    nxt_q.sda_d = sda_s;
    nxt_q.tog_d = tog_s;

    // First snapshot of pins after reset release
    if (!q_ff.init_done)
    begin
      nxt_q.snap = pin_s;
      nxt_q.init_done = 1'h1;
    end

    // Pending while an input pin differs from snapshot
    nxt_q.int_oe = q_ff.init_done & (|((pin_s ^ q_ff.snap) & q_ff.cfg));

    if (stop_ev)
    begin
      // Stop ends any transfer, bus released
      nxt_q.st = GXP_ST_IDLE;
      nxt_q.sda_oe = 1'h0;
    end
    else if (start_ev)
    begin
      // Start or repeated start, pointer kept
      nxt_q.st = GXP_ST_ADDR;
      nxt_q.bcnt = GXP_CNT_CLR;
      nxt_q.sda_oe = 1'h0;
    end
    else
    begin
      case (q_ff.st)
        GXP_ST_ADDR:
        begin
          // Collect address and direction
          if (rise_ev)
          begin
            nxt_q.rx = {q_ff.rx[6:0], smp_bit};
            nxt_q.bcnt = q_ff.bcnt + GXP_CNT_ONE;
          end
          else if (fall_ev && q_ff.bcnt == GXP_BYTE_BITS)
          begin
            nxt_q.bcnt = GXP_CNT_CLR;
            nxt_q.rw = q_ff.rx[0];
            if (q_ff.rx[7:1] == {ADDR_BASE, strap_s})
            begin
              // Own address: acknowledge
              nxt_q.st = GXP_ST_ADDR_ACK;
              nxt_q.sda_oe = 1'h1;
            end
            else
              nxt_q.st = GXP_ST_IGNORE;
          end
        end
        GXP_ST_ADDR_ACK:
        begin
          // Read: load selected register at ack rise
          if (rise_ev && q_ff.rw)
            nxt_q.tx = reg_read(q_ff.ptr, in_val, q_ff);
          else if (fall_ev && q_ff.rw)
          begin
            // Present first data bit
            nxt_q.st = GXP_ST_RDATA;
            nxt_q.sda_oe = ~q_ff.tx[7];
            nxt_q.tx = {q_ff.tx[6:0], 1'h0};
            nxt_q.bcnt = GXP_CNT_ONE;
          end
          else if (fall_ev)
          begin
            // Write: command byte follows
            nxt_q.st = GXP_ST_CMD;
            nxt_q.sda_oe = 1'h0;
          end
        end
        GXP_ST_CMD:
        begin
          // Collect command byte
          if (rise_ev)
          begin
            nxt_q.rx = {q_ff.rx[6:0], smp_bit};
            nxt_q.bcnt = q_ff.bcnt + GXP_CNT_ONE;
          end
          else if (fall_ev && q_ff.bcnt == GXP_BYTE_BITS)
          begin
            nxt_q.ptr = q_ff.rx;
            nxt_q.bcnt = GXP_CNT_CLR;
            nxt_q.st = GXP_ST_CMD_ACK;
            nxt_q.sda_oe = 1'h1;
          end
        end
        GXP_ST_CMD_ACK:
        begin
          // Release after command ack
          if (fall_ev)
          begin
            nxt_q.st = GXP_ST_WDATA;
            nxt_q.sda_oe = 1'h0;
          end
        end
        GXP_ST_WDATA:
        begin
          // Collect data byte
          if (rise_ev)
          begin
            nxt_q.rx = {q_ff.rx[6:0], smp_bit};
            nxt_q.bcnt = q_ff.bcnt + GXP_CNT_ONE;
          end
          else if (fall_ev && q_ff.bcnt == GXP_BYTE_BITS)
          begin
            nxt_q.bcnt = GXP_CNT_CLR;
            nxt_q.st = GXP_ST_WACK;
            nxt_q.sda_oe = 1'h1;
          end
        end
        GXP_ST_WACK:
        begin
          // Store byte at ack rise, then move to partner
          if (rise_ev)
          begin
            case (q_ff.ptr)
              GXP_REG_OUT0: nxt_q.outp[7:0] = q_ff.rx;
              GXP_REG_OUT1: nxt_q.outp[15:8] = q_ff.rx;
              GXP_REG_POL0: nxt_q.pol[7:0] = q_ff.rx;
              GXP_REG_POL1: nxt_q.pol[15:8] = q_ff.rx;
              GXP_REG_CFG0: nxt_q.cfg[7:0] = q_ff.rx;
              GXP_REG_CFG1: nxt_q.cfg[15:8] = q_ff.rx;
              GXP_REG_PU0: nxt_q.pu[7:0] = q_ff.rx;
              GXP_REG_PU1: nxt_q.pu[15:8] = q_ff.rx;
              // Input ports and unmapped indices ignore writes
              default: nxt_q.ptr = q_ff.ptr;
            endcase
            nxt_q.ptr = q_ff.ptr ^ GXP_PAIR_FLIP;
          end
          else if (fall_ev)
          begin
            // Further bytes accepted without limit
            nxt_q.st = GXP_ST_WDATA;
            nxt_q.sda_oe = 1'h0;
          end
        end
        GXP_ST_RDATA:
        begin
          // Shift data out on each falling edge
          if (fall_ev && q_ff.bcnt == GXP_BYTE_BITS)
          begin
            nxt_q.st = GXP_ST_RACK;
            nxt_q.sda_oe = 1'h0;
            nxt_q.bcnt = GXP_CNT_CLR;
          end
          else if (fall_ev)
          begin
            nxt_q.sda_oe = ~q_ff.tx[7];
            nxt_q.tx = {q_ff.tx[6:0], 1'h0};
            nxt_q.bcnt = q_ff.bcnt + GXP_CNT_ONE;
          end
        end
        GXP_ST_RACK:
        begin
          if (rise_ev)
          begin
            // Pointer moves to partner on every read byte
            nxt_q.ptr = q_ff.ptr ^ GXP_PAIR_FLIP;
            nxt_q.acked = ~smp_bit;
            // Reading an input port refreshes its snapshot
            if (q_ff.ptr == GXP_REG_IN0)
              nxt_q.snap[7:0] = pin_s[7:0];
            if (q_ff.ptr == GXP_REG_IN1)
              nxt_q.snap[15:8] = pin_s[15:8];
            // Next byte captured at ack rise
            nxt_q.tx = reg_read(q_ff.ptr ^ GXP_PAIR_FLIP, in_val, q_ff);
          end
          else if (fall_ev && q_ff.acked)
          begin
            // Master wants more: present first bit
            nxt_q.st = GXP_ST_RDATA;
            nxt_q.sda_oe = ~q_ff.tx[7];
            nxt_q.tx = {q_ff.tx[6:0], 1'h0};
            nxt_q.bcnt = GXP_CNT_ONE;
          end
          else if (fall_ev)
            // Not acknowledged: last byte, wait for stop
            nxt_q.st = GXP_ST_IGNORE;
        end
        GXP_ST_IDLE, GXP_ST_IGNORE:
        begin
          // Bus idle or addressed elsewhere
          nxt_q.sda_oe = 1'h0;
        end
        default:
        begin
          // Recover from any stray encoding
          nxt_q.st = GXP_ST_IDLE;
          nxt_q.sda_oe = 1'h0;
        end
      endcase
    end
  end

  // ****************************************
  // State register
  // ****************************************

  // Reset loads every default and idles the engine
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      q_ff <= '0;
      q_ff.st <= GXP_ST_IDLE;
      q_ff.outp <= GXP_OUT_RST;
      q_ff.pol <= GXP_POL_RST;
      q_ff.cfg <= GXP_CFG_RST;
      q_ff.pu <= GXP_PU_RST;
    end
    else
      q_ff <= nxt_q;
  end

  // ****************************************
  // Pins
  // ****************************************

  // Drivers enabled only for output pins
  assign gpio_oe = ~q_ff.cfg;
  // Level from output register
  assign gpio_out = q_ff.outp;
  // Pull-up off where its bit is 0
  assign gpio_pu_en = q_ff.pu;
  // Open-drain lines only ever pull low
  assign sda_out = 1'h0;
  assign sda_oe = q_ff.sda_oe;
  assign int_out = 1'h0;
  assign int_oe = q_ff.int_oe;

endmodule
`default_nettype wire

// ### verification/gxp_core_sva.sv
// Port-level assertion checker for the GPIO expander core
`timescale 1ns/1ps
`default_nettype none
module gxp_core_sva
  import gxp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic scl_clk,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic [gxp_pkg::GXP_STRAP_W-1:0] addr_pin,
  input wire logic [gxp_pkg::GXP_IO_W-1:0] gpio_in,
  input wire logic [gxp_pkg::GXP_IO_W-1:0] gpio_out,
  input wire logic [gxp_pkg::GXP_IO_W-1:0] gpio_oe,
  input wire logic [gxp_pkg::GXP_IO_W-1:0] gpio_pu_en,
  input wire logic int_out,
  input wire logic int_oe
);
  // ****************
  // Helper logic
  // ****************
  logic [15:0] pin_ff; // Last pin levels
  logic [15:0] oe_ff; // Last pin directions
  logic [3:0] quiet_ff; // Cycles since pins or directions moved
  // Count quiet cycles, saturating
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pin_ff <= 16'h0000;
      oe_ff <= 16'h0000;
      quiet_ff <= 4'hF;
    end
    else
    begin
      pin_ff <= gpio_in;
      oe_ff <= gpio_oe;
      if (gpio_in != pin_ff || gpio_oe != oe_ff)
        quiet_ff <= 4'h0;
      else if (quiet_ff != 4'hF)
        quiet_ff <= quiet_ff + 4'h1;
    end
  end
  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);
  // Stop: data rises while the bus clock is high
  sequence stop_seen;
    scl_clk && $rose(sda_in);
  endsequence
  // ****************
  // Assertions
  // ****************
  a_sda_open_drain: assert property (sda_out == 1'b0)
    else $error("sda_out not low");
  a_int_open_drain: assert property (int_out == 1'b0)
    else $error("int_out not low");
  a_reset_load: assert property ($rose(rst_b) |-> gpio_out == GXP_OUT_RST && gpio_oe == ~GXP_CFG_RST
    && gpio_pu_en == GXP_PU_RST && !int_oe && !sda_oe) else $error("bad values after reset");
  a_out_on_ack: assert property ($changed(gpio_out) |-> scl_clk)
    else $error("gpio_out moved outside an ack pulse");
  a_dir_on_ack: assert property (!scl_clk ##1 !scl_clk |-> $stable(gpio_oe))
    else $error("gpio_oe moved while bus clock low");
  a_pu_on_ack: assert property ($changed(gpio_pu_en) |-> $past(scl_clk) && $past(scl_clk, 2))
    else $error("gpio_pu_en moved outside an ack pulse");
  a_no_out_int: assert property ($rose(int_oe) |->
    !(gpio_oe == 16'hFFFF && $past(gpio_oe) == 16'hFFFF && $past(gpio_oe, 2) == 16'hFFFF))
    else $error("interrupt with all pins driven");
  a_int_cause: assert property ($rose(int_oe) |-> quiet_ff <= 4'h6)
    else $error("interrupt without a pin change");
  a_int_clear: assert property ($fell(int_oe) |-> quiet_ff <= 4'h6 || scl_clk)
    else $error("interrupt cleared without cause");
  a_drive_in_low: assert property ($rose(sda_oe) |-> !scl_clk && !$past(scl_clk, 2))
    else $error("sda driven outside a low phase");
  a_stop_release: assert property (stop_seen |-> ##4 !sda_oe [*4])
    else $error("sda driven after stop");
  c_int_set: cover property ($rose(int_oe));
  c_read_clear: cover property ($fell(int_oe) && scl_clk);
  c_dev_drive: cover property ($rose(sda_oe));
endmodule

bind gxp_core gxp_core_sva u_gxp_core_sva (.ref_clk(ref_clk), .rst_b(rst_b), .scl_clk(scl_clk),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .addr_pin(addr_pin), .gpio_in(gpio_in),
  .gpio_out(gpio_out), .gpio_oe(gpio_oe), .gpio_pu_en(gpio_pu_en), .int_out(int_out), .int_oe(int_oe));
`default_nettype wire

// ### verification/gxp_master_model.sv
// Two-wire bus master model facing the expander
`timescale 1ns/1ps
`default_nettype none
module gxp_master_model (
  output logic scl,
  output logic sda_drv,
  input wire logic sda_w
);
  localparam int QTR = 400; // Quarter bit time in ns
  // Idle bus: both lines high and still
  initial
  begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // Start or repeated start from a high data line
  task automatic start_c();
    sda_drv = 1'b1;
    #37;
    #(QTR) scl = 1'b1;
    #(QTR) sda_drv = 1'b0;
    #(QTR) scl = 1'b0;
    #(QTR);
  endtask
  // Stop, then the clock stands high
  task automatic stop_c();
    sda_drv = 1'b0;
    #(QTR) scl = 1'b1;
    #(QTR) sda_drv = 1'b1;
    #(QTR);
  endtask
  // Eight bits msb first, then the ninth; last high releases it
  task automatic byte_x(input logic [7:0] tx, input logic last, output logic [7:0] rx, output logic ack);
    logic [8:0] sh;
    sh = {tx, last};
    for (int i = 8; i >= 0; i--)
    begin
      sda_drv = sh[i];
      #(QTR) scl = 1'b1;
      #(QTR) sh[i] = sda_w;
      #(QTR) scl = 1'b0;
      #(QTR);
    end
    rx = sh[8:1];
    ack = sh[0];
  endtask
endmodule
`default_nettype wire

// ### verification/gxp_core_test.sv
// Self-checking bench for the GPIO expander core
`timescale 1ns/1ps
`default_nettype none
module gxp_core_test;
  import gxp_pkg::*;
  localparam logic [3:0] BASE = 4'hA; // Arbitrary upper address bits
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic scl, msda, sda_in, sda_out, sda_oe, int_out, int_oe, ak;
  logic [2:0] addr_pin;
  logic [15:0] ext = 16'h0000; // External load levels
  logic [15:0] gpio_in, gpio_out, gpio_oe, gpio_pu_en;
  logic [15:0] out_m = GXP_OUT_RST; // Bench copies of registers
  logic [15:0] pol_m = GXP_POL_RST;
  logic [15:0] cfg_m = GXP_CFG_RST;
  logic [15:0] pu_m = GXP_PU_RST;
  logic [7:0] ptr_m = 8'h00; // Expected register pointer
  logic [7:0] rb;
  int seed = 3;
  int fail_count = 0;
  int checks = 0;
  always #50 ref_clk = ~ref_clk;
  // Open-drain data wire with pull-up
  assign sda_in = msda & ~(sda_oe & ~sda_out);
  // Driven pins follow the output register, the rest the load
  assign gpio_in = (gpio_oe & gpio_out) | (~gpio_oe & ext);
  gxp_core #(.ADDR_BASE(BASE)) u_gxp_core (.ref_clk(ref_clk), .rst_b(rst_b), .scl_clk(scl),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .addr_pin(addr_pin), .gpio_in(gpio_in),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe), .gpio_pu_en(gpio_pu_en), .int_out(int_out), .int_oe(int_oe));
  gxp_master_model u_gxp_master_model (.scl(scl), .sda_drv(msda), .sda_w(sda_in));
  // ****************
  // Expectations and checks
  // ****************
  // Expected byte read from a register index
  function automatic logic [7:0] exp_rd(input logic [7:0] c);
    logic [15:0] w;
    case (c[7:1])
      7'h00: w = ((~cfg_m & out_m) | (cfg_m & ext)) ^ pol_m;
      7'h01: w = out_m;
      7'h02: w = pol_m;
      7'h03: w = cfg_m;
      7'h04: w = pu_m;
      default: w = 16'h0000;
    endcase
    return c[0] ? w[15:8] : w[7:0];
  endfunction
  // Update bench copy; input ports and unmapped ignore writes
  task automatic set_m(input logic [7:0] c, input logic [7:0] d);
    logic [15:0] m;
    m = c[0] ? 16'hFF00 : 16'h00FF;
    case (c[7:1])
      7'h01: out_m = (out_m & ~m) | ({d, d} & m);
      7'h02: pol_m = (pol_m & ~m) | ({d, d} & m);
      7'h03: cfg_m = (cfg_m & ~m) | ({d, d} & m);
      7'h04: pu_m = (pu_m & ~m) | ({d, d} & m);
      default: m = 16'h0000;
    endcase
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Start, write address, command byte
  task automatic hdr(input logic [7:0] c);
    u_gxp_master_model.start_c();
    u_gxp_master_model.byte_x({BASE, addr_pin, 1'b0}, 1'b1, rb, ak);
    chk("addr ack", 16'h0000, {15'h0000, ak});
    u_gxp_master_model.byte_x(c, 1'b1, rb, ak);
    chk("cmd ack", 16'h0000, {15'h0000, ak});
    ptr_m = c;
  endtask
  // Write n bytes alternating d0, d1
  task automatic wr(input logic [7:0] c, input int n, input logic [7:0] d0, input logic [7:0] d1);
    hdr(c);
    for (int i = 0; i < n; i++)
    begin
      u_gxp_master_model.byte_x(i[0] ? d1 : d0, 1'b1, rb, ak);
      chk("data ack", 16'h0000, {15'h0000, ak});
      set_m(ptr_m, i[0] ? d1 : d0);
      ptr_m = ptr_m ^ GXP_PAIR_FLIP;
    end
    u_gxp_master_model.stop_c();
  endtask
  // Read n bytes, with or without a command first
  task automatic rd(input logic wc, input logic [7:0] c, input int n);
    if (wc)
      hdr(c);
    u_gxp_master_model.start_c();
    u_gxp_master_model.byte_x({BASE, addr_pin, 1'b1}, 1'b1, rb, ak);
    chk("read addr ack", 16'h0000, {15'h0000, ak});
    for (int i = 0; i < n; i++)
    begin
      u_gxp_master_model.byte_x(8'hFF, i == n - 1, rb, ak);
      chk("read byte", {8'h00, exp_rd(ptr_m)}, {8'h00, rb});
      ptr_m = ptr_m ^ GXP_PAIR_FLIP;
    end
    u_gxp_master_model.stop_c();
  endtask
  // Wait, bounded, for the interrupt level
  task automatic int_is(input logic v);
    int k;
    k = 0;
    while (int_oe !== v && k < 20)
    begin
      @(negedge ref_clk);
      k++;
    end
    chk("int_oe", {15'h0000, v}, {15'h0000, int_oe});
  endtask
  task automatic end_of_test();
    $display("Checks %0d errors %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ****************
  // Main sequence
  // ****************
  initial
  begin
    addr_pin = 3'($random(seed));
    repeat (20) @(negedge ref_clk);
    chk("out reset", GXP_OUT_RST, gpio_out);
    chk("oe reset", 16'h0000, gpio_oe);
    chk("pu reset", GXP_PU_RST, gpio_pu_en);
    chk("int reset", 16'h0000, {15'h0000, int_oe});
    rst_b = 1'b1;
    repeat (6) @(negedge ref_clk);
    for (int r = 0; r < 4; r++)
    begin
      wr(GXP_REG_CFG1, 3, 8'($random(seed)), 8'($random(seed)));
      chk("direction", ~cfg_m, gpio_oe);
      wr(GXP_REG_OUT0, 2, 8'($random(seed)), 8'($random(seed)));
      chk("outputs", out_m, gpio_out);
      wr(GXP_REG_PU1, 2, 8'($random(seed)), 8'($random(seed)));
      chk("pull-ups", pu_m, gpio_pu_en);
      wr(GXP_REG_POL0, 2, 8'($random(seed)), 8'($random(seed)));
      @(negedge ref_clk);
      ext = 16'($random(seed));
      rd(1'b1, GXP_REG_OUT1, 2);
      rd(1'b1, GXP_REG_IN1, 2);
      u_gxp_master_model.start_c();
      u_gxp_master_model.byte_x({BASE, ~addr_pin, 1'b0}, 1'b1, rb, ak);
      chk("foreign addr", 16'h0001, {15'h0000, ak});
      u_gxp_master_model.stop_c();
      rd(1'b0, 8'h00, 1);
      wr(GXP_REG_IN0, 2, 8'($random(seed)), 8'($random(seed)));
      rd(1'b0, 8'h00, 1);
      rd(1'b1, 8'h0A, 1);
    end
    // All pins input, refresh both snapshots
    wr(GXP_REG_CFG0, 2, 8'hFF, 8'hFF);
    rd(1'b1, GXP_REG_IN0, 2);
    int_is(1'b0);
    for (int b = 0; b < 16; b += 5)
    begin
      @(negedge ref_clk);
      ext[b] = ~ext[b];
      int_is(1'b1);
      @(negedge ref_clk);
      ext[b] = ~ext[b];
      int_is(1'b0);
      @(negedge ref_clk);
      ext[b] = ~ext[b];
      int_is(1'b1);
      rd(1'b1, b < 8 ? GXP_REG_IN0 : GXP_REG_IN1, 1);
      int_is(1'b0);
    end
    // Driven pin toggling must stay silent
    wr(GXP_REG_CFG0, 1, 8'hFE, 8'hFE);
    wr(GXP_REG_OUT0, 1, ~out_m[7:0], 8'h00);
    repeat (10) @(negedge ref_clk);
    chk("output pin int", 16'h0000, {15'h0000, int_oe});
    // Second reset in mid-run: loads quiet, pins settle before release
    ext = 16'h0000;
    rst_b = 1'b0;
    repeat (2) @(negedge ref_clk);
    chk("out rerst", GXP_OUT_RST, gpio_out);
    chk("oe rerst", 16'h0000, gpio_oe);
    chk("pu rerst", GXP_PU_RST, gpio_pu_en);
    rst_b = 1'b1;
    repeat (6) @(negedge ref_clk);
    chk("sda rerst", 16'h0000, {15'h0000, sda_oe});
    chk("int rerst", 16'h0000, {15'h0000, int_oe});
    end_of_test();
  end
  // Watchdog: the run needs about 3 ms
  initial
  begin
    #6000000;
    fail_count++;
    end_of_test();
  end
endmodule
`default_nettype wire
